// ===== testbench/fieldbus_master_model.sv
// Avalon-MM master standing in for the fieldbus controller.
// Assumes a slave that answers through waitrequest on the same clock.
`timescale 1ns/10ps
module fieldbus_master_model (
  input wire clock,
  output logic [7:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable,
  input wire [31:0] readdata,
  input wire waitrequest
);
  initial begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'hF;
  end
  // Released address and data lines show the inverse of the last value, so a slave that
  // samples them outside an access cannot pass by luck.
  task automatic access(input bit wr, input [7:0] a, input [31:0] d,
    output [31:0] q);
    @(posedge clock);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    do @(posedge clock); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    address <= ~a;
    writedata <= ~d;
  endtask
endmodule // fieldbus_master_model

// ===== testbench/param_channel_codec_chk.sv
// Checker for the parameter channel codec, bound to its top module.
// Assumes one clock domain and a master that idles between accesses.
`timescale 1ns/10ps
module param_channel_codec_chk (
  input wire clock,
  input wire nrst,
  input wire clock_en,
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  input wire [31:0] readdata,
  input wire waitrequest,
  input wire dx_enable
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  wire req = read | write;
  wire done = req & ~waitrequest & clock_en;
  wire cmd_done = done & write & (address[7:2] == 6'h03);
  logic cfg_ok_q;
  // The last exchange setting is kept so that a rising enable can be judged.
  always @(posedge clock or negedge nrst) begin
    if (!nrst)
      cfg_ok_q <= 1'b0;
    else if (done && write && address[7:2] == 6'h0E && byteenable == 4'hF)
      cfg_ok_q <= writedata[4:0] <= 5'h0C && writedata[10:8] <= 3'h4 &&
        writedata[16];
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_start;
    !req ##1 (req && clock_en);
  endsequence
  AST_ONE_WAIT: assert property (s_start |-> waitrequest ##1 !waitrequest)
    else $error("access did not take exactly one wait cycle");
  AST_IDLE_FREE: assert property (!req |-> !waitrequest)
    else $error("waitrequest high with no access");
  AST_RESET_VAL: assert property ($rose(nrst) |-> readdata == 32'h0 &&
    !dx_enable) else $error("outputs not cleared by reset");
  AST_RD_HOLD: assert property (!(read && clock_en) |=> $stable(readdata))
    else $error("readdata changed without a read");
  AST_FREEZE: assert property (!clock_en |=> $stable(dx_enable) &&
    $stable(readdata)) else $error("outputs moved while frozen");
  AST_DX_LIMITS: assert property
    ($rose(dx_enable) |-> cfg_ok_q)
    else $error("exchange enabled with an illegal setting");
  AST_DX_CAUSE: assert property ($changed(dx_enable) |-> $past(cmd_done) ||
    $past(cmd_done, 2) || $past(cmd_done, 3))
    else $error("exchange enable moved without a command");
  AST_UNMAPPED: assert property (done && read && address[7:2] > 6'h0F |->
    readdata == 32'h0) else $error("unmapped read not zero");
endmodule // param_channel_codec_chk

bind param_channel_codec param_channel_codec_chk i_param_channel_codec_chk (
  .clock(clock), .nrst(nrst), .clock_en(clock_en), .address(address),
  .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .dx_enable(dx_enable));

// ===== testbench/test_param_channel_codec.sv
// Self-checking bench for the parameter channel codec.
// Assumes the codec and the master model on one 200 MHz clock.
`timescale 1ns/10ps
`include "param_channel_defs.vh"
module test_param_channel_codec;
  logic clock;
  logic nrst;
  logic clock_en;
  wire [7:0] address;
  wire read;
  wire write;
  wire [31:0] writedata;
  wire [3:0] byteenable;
  wire [31:0] readdata;
  wire waitrequest;
  wire dx_enable;
  integer num_errors = 0;
  integer n_compared = 0;
  integer cycles = 0;
  integer seed = 32'hac80c8a9;
  param_channel_codec i_param_channel_codec (.clock(clock), .nrst(nrst),
    .clock_en(clock_en), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .dx_enable(dx_enable));
  fieldbus_master_model i_fieldbus_master_model (.clock(clock),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (num_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string what, input [31:0] seen, input [31:0] e);
    n_compared = n_compared + 1;
    if (seen !== e) begin
      num_errors = num_errors + 1;
      $display("ERROR %s expected %h seen %h", what, e, seen);
    end
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    logic [31:0] q;
    i_fieldbus_master_model.access(1'b1, a, d, q);
  endtask
  task automatic rd(input [7:0] a, output [31:0] q);
    i_fieldbus_master_model.access(1'b0, a, 32'h0, q);
  endtask
  // Codes 1 to 3 leave as 6 to 8; a read carries no value words.
  function automatic logic [63:0] enc_exp(input [3:0] c, input [10:0] p,
    input [7:0] x, input [7:0] pg, input [1:0] f, input [31:0] v);
    logic [3:0] k;
    logic [31:0] w;
    k = (c < 4'h4) ? c + 4'h5 : c;
    case (f)
      2'h0: w = {24'h0, v[7:0]};
      2'h1: w = {16'h0, v[15:0]};
      2'h2: w = v;
      default: w = {v[15:0], 6'h3F, v[25:16]};
    endcase
    if (k == 4'h6)
      w = 32'h0;
    return {k, 1'b0, p, x, pg, w};
  endfunction
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 32'h4E20) begin
      num_errors = num_errors + 1;
      stop_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q;
    logic [63:0] e;
    logic [15:0] n;
    logic [15:0] d;
    logic [3:0] c;
    logic [1:0] f;
    logic [7:0] x;
    logic [31:0] v;
    logic [127:0] offs;
    logic [63:0] pages;
    logic [31:0] dxs [6];
    offs = `PAGE_OFFSETS;
    pages = `PAGE_CODES;
    dxs = '{32'h1040D, 32'h1040C, 32'h1050C, 32'h10101, 32'h0040C,
      32'h1040C};
    nrst = 1'b0;
    clock_en = 1'b1;
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < 6; j++) begin
        c = 24'h876321 >> (4 * j);
        d = (j == 0) ? 16'h0 : (j == 5) ? 16'h07CF :
          16'($unsigned($random(seed)) % 32'h7D0);
        n = d + offs[16*i +: 16];
        x = $random(seed);
        v = $random(seed);
        f = $random(seed);
        wr(`REG_NUMBER, {16'h0, n});
        wr(`REG_CTRL, {14'h0, f, x, 4'h0, c});
        wr(`REG_VALUE, v);
        wr(`REG_CMD, 32'h1);
        e = enc_exp(c, d[10:0], x, pages[8*i +: 8], f, v);
        rd(`REG_CHOUT01, q);
        check("chout01", q, e[63:32]);
        rd(`REG_CHOUT23, q);
        check("chout23", q, e[31:0]);
        wr(`REG_CHIN01, e[63:32]);
        wr(`REG_CHIN23, e[31:0]);
        wr(`REG_CMD, 32'h2);
        rd(`REG_DEC_RESULT, q);
        check("dec_result", q, {x, 4'h0, e[63:60], n});
        rd(`REG_DEC_VALUE, q);
        check("dec_value", q, (e[63:60] == 4'h8) ? e[31:0] : {16'h0, e[15:0]});
      end
    end
    for (int k = 0; k < 2; k++) begin
      wr(`REG_STATUS, 32'h7E);
      wr(`REG_NUMBER, k ? 32'h5 : 32'hFA0);
      wr(`REG_CTRL, k ? 32'h4 : 32'h7);
      wr(`REG_CMD, 32'h1);
      rd(`REG_STATUS, q);
      check("enc_flags", q & 32'hC, k ? 32'h8 : 32'h4);
      v = k ? 32'h9005_0000 : 32'h7005_0011;
      wr(`REG_CHIN01, v);
      wr(`REG_CHIN23, 32'h0);
      wr(`REG_CMD, 32'h2);
      rd(`REG_CHOUT01, q);
      check("err_word1", q, {4'h7, v[27:0]});
      rd(`REG_CHOUT23, q);
      check("err_number", q, k ? 32'h6A : 32'h0);
    end
    // Cases: full count, count too high, length too long, count zero.
    for (int k = 0; k < 4; k++) begin
      wr(`REG_STATUS, 32'h7E);
      x = 32'h00012827 >> (8 * k);
      v = $random(seed);
      wr(`REG_ACYC_HDR, {x, 8'h01, 8'h01, v[7:1], 1'b1});
      wr(`REG_ACYC_ADDR, {v[31:16] | 16'h1, 8'h00, k[0] ? 8'h20 : 8'h10});
      wr(`REG_ACYC_IDX_LEN, {16'(64'h0001_00F1_0010_00F0 >> (16 * k)), 16'h0});
      wr(`REG_CMD, 32'h4);
      rd(`REG_STATUS, q);
      check("acyc_flags", q & 32'h30, (k == 2) ? 32'h20 :
        (k == 0) ? 32'h0 : 32'h10);
      rd(`REG_ACYC_RESP, q);
      check("acyc_resp", q, {x, 8'h01, (k == 0) ? 8'h01 : 8'h81, v[7:1], 1'b1});
    end
    for (int k = 0; k < 6; k++) begin
      wr(`REG_STATUS, 32'h7E);
      wr(`REG_DX_CFG, dxs[k]);
      wr(`REG_CMD, 32'h8);
      rd(`REG_STATUS, q);
      check("dx_reject", q & 32'h40, (k % 2) ? 32'h0 : 32'h40);
      check("dx_enable", {31'h0, dx_enable}, k % 2);
    end
    rd(8'h40, q);
    check("unmapped", q, 32'h0);
    rd(`REG_CMD, q);
    check("cmd_read", q, 32'h0);
    clock_en <= 1'b0;
    repeat (4) @(posedge clock);
    clock_en <= 1'b1;
    check("frozen_dx", {31'h0, dx_enable}, 32'h1);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    check("reset_dx", {31'h0, dx_enable}, 32'h0);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    rd(`REG_DX_CFG, q);
    check("reset_cfg", q, 32'h0);
    stop_test;
  end
endmodule // test_param_channel_codec

// ===== verilog/page_index_map.v
// Page index map: parameter number to offset and page code, and back.
// Assumes purely combinational use from the codec on the same clock.
`timescale 1ns/10ps
`include "param_channel_defs.vh"

module page_index_map #(
  parameter N = `PAGE_ENTRIES
) (
  input wire [15:0] number,
  input wire [7:0] page,
  output wire [15:0] enc_offset,
  output wire [7:0] enc_page,
  output wire enc_ok,
  output wire [15:0] dec_offset,
  output wire dec_ok
);
  localparam [16*N-1:0] OFFS = `PAGE_OFFSETS;
  localparam [8*N-1:0] PAGES = `PAGE_CODES;

  wire [16*(N+1)-1:0] eoff_c;
  wire [8*(N+1)-1:0] epg_c;
  wire [16*(N+1)-1:0] doff_c;
  wire [N:0] ehit_c;
  wire [N:0] dhit_c;

  assign eoff_c[15:0] = 16'h0000;
  assign epg_c[7:0] = 8'h00;
  assign doff_c[15:0] = 16'h0000;
  assign ehit_c[0] = 1'b0;
  assign dhit_c[0] = 1'b0;

  // The ranges are disjoint, so at most one entry hits and ORing is safe.
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_entry
      wire [16:0] lo = {1'b0, OFFS[16*i +: 16]};
      wire [16:0] hi = lo + `PAGE_RANGE;
      wire eh = ({1'b0, number} >= lo) && ({1'b0, number} < hi); // [RULE2]
      wire dh = (page == PAGES[8*i +: 8]); // [RULE23]
      assign ehit_c[i+1] = ehit_c[i] | eh;
      assign dhit_c[i+1] = dhit_c[i] | dh;
      assign eoff_c[16*(i+1) +: 16] = eoff_c[16*i +: 16] |
        (eh ? OFFS[16*i +: 16] : 16'h0000);
      assign epg_c[8*(i+1) +: 8] = epg_c[8*i +: 8] |
        (eh ? PAGES[8*i +: 8] : 8'h00); // [RULE3]
      assign doff_c[16*(i+1) +: 16] = doff_c[16*i +: 16] |
        (dh ? OFFS[16*i +: 16] : 16'h0000);
    end
  endgenerate

  assign enc_offset = eoff_c[16*N +: 16];
  assign enc_page = epg_c[8*N +: 8];
  assign enc_ok = ehit_c[N];
  assign dec_offset = doff_c[16*N +: 16];
  assign dec_ok = dhit_c[N];
endmodule // page_index_map

// ===== verilog/param_channel_codec.v
// Parameter channel codec: builds and parses the four-word cyclic channel,
// checks acyclic read headers and slave-to-slave exchange settings.
// Assumes an Avalon-MM master on the same clock and a 32-bit data bus.
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/10ps
`include "param_channel_defs.vh"

// Behaviour
// RULE1: Numbers below 2000 go unchanged into the number field, page zero.
// RULE2: Numbers from 2000 carry number minus offset; decode adds it back.
// RULE3: Page byte in word two low byte encodes the range offset.
// RULE4: Element index sits in bits 15 to 8 of word two.
// RULE5: 8-bit value in word four low byte, rest and word three zero.
// RULE6: 16-bit value fills word four; 32-bit spans words three and four.
// RULE7: Connector: source in word three, object 15:10, index 9:0.
// RULE8: Request code in bits 15 to 12; 6 reads, 7 writes word.
// RULE9: Read requests carry zero in words three and four; ignored.
// RULE10: Connector drive object is always 63.
// RULE11: Exchange accepts at most 12 words per drive, 4 links per publisher.
// RULE12: Slave-to-slave exchange is allowed only over the first fieldbus.
// RULE13: Acyclic data set transfers carry at most 240 bytes.
// RULE14: Acyclic read starts with reference 01..FF, then request code 01.
// RULE15: Header byte 2 is 01, byte 3 parameter count 01..27.
// RULE16: Attribute 10 reads value, 20 reads description.
// RULE17: Index count lies in 00..EA, 00 when unindexed.
// RULE18: Address block parameter number lies in 0001..FFFF.
// RULE19: First index 0000..FFFF, 0000 for an unindexed parameter.
// RULE20: Code 8 writes double word; codes 1,2,3 equal 6,7,8.
// RULE21: Unprocessable request answers code 7, error number in top word; the code puts it in word four, low half of chout23.
// RULE22: Parameter count outside 01..27 gives a negative acyclic response.
// RULE23: Unknown page code makes the parameter number illegal.
module param_channel_codec (
  input wire clock,
  input wire nrst,
  input wire clock_en,
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output wire [31:0] readdata,
  output wire waitrequest,
  output wire dx_enable
);

  ////////////////////////////////////////////////////////////////////////////

  localparam [1:0] S_IDLE = 2'b01;
  localparam [1:0] S_WORK = 2'b10;
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    reg [31:0] m;
    begin
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  // Returns {legal, canonical code}; the old codes fold onto the new ones.
  function [4:0] canon_code;
    input [3:0] c;
    begin
      case (c)
        4'h1, 4'h6: canon_code = {1'b1, `RQ_READ_FIELD}; // [RULE20]
        4'h2, 4'h7: canon_code = {1'b1, `RQ_WRITE_WORD}; // [RULE20]
        4'h3, 4'h8: canon_code = {1'b1, `RQ_WRITE_DWORD}; // [RULE20]
        default: canon_code = {1'b0, c};
      endcase
    end
  endfunction

  reg ack_q;
  reg [31:0] readdata_q;
  reg [1:0] state_q;
  reg [3:0] op_q;
  reg [15:0] num_q;
  reg [31:0] ctrl_q;
  reg [31:0] value_q;
  reg [31:0] chin01_q;
  reg [31:0] chin23_q;
  reg [31:0] chout01_q;
  reg [31:0] chout23_q;
  reg [31:0] dec_result_q;
  reg [31:0] dec_value_q;
  reg [31:0] hdr_q;
  reg [31:0] addr_q;
  reg [31:0] idx_len_q;
  reg [31:0] dx_cfg_q;
  reg [31:0] acyc_resp_q;
  reg [6:0] status_q;
  reg dx_enable_q;
  wire [15:0] enc_offset;
  wire [7:0] enc_page;
  wire enc_ok;
  wire [15:0] dec_offset;
  wire dec_ok;
  wire bus_go = (read | write) & ~ack_q;
  wire wr_go = write & ack_q;
  wire [7:0] wa = {address[7:2], 2'b00};
  wire [31:0] num_wr = merge({16'h0000, num_q}, writedata, byteenable);
  assign waitrequest = (read | write) & ~ack_q;
  assign readdata = readdata_q;
  assign dx_enable = dx_enable_q;

  page_index_map #(.N(`PAGE_ENTRIES)) u_map (
    .number(num_q),
    .page(chin01_q[7:0]),
    .enc_offset(enc_offset),
    .enc_page(enc_page),
    .enc_ok(enc_ok),
    .dec_offset(dec_offset),
    .dec_ok(dec_ok)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Encoder: number, code, element and value into four channel words.
  reg [4:0] enc_code;
  reg [15:0] enc_diff;
  reg [15:0] enc_w0;
  reg [15:0] enc_w1;
  reg [15:0] enc_w2;
  reg [15:0] enc_w3;
  always @* begin
    enc_code = canon_code(ctrl_q[3:0]);
    enc_diff = num_q - enc_offset; // [RULE1] [RULE2]
    enc_w0 = {enc_code[3:0], 1'b0, enc_diff[10:0]}; // [RULE8]
    enc_w1 = {ctrl_q[15:8], enc_page}; // [RULE3] [RULE4]
    case (ctrl_q[17:16])
      `FMT_8BIT: begin
        enc_w2 = 16'h0000; // [RULE5]
        enc_w3 = {8'h00, value_q[7:0]}; // [RULE5]
      end
      `FMT_16BIT: begin
        enc_w2 = 16'h0000; // [RULE6]
        enc_w3 = value_q[15:0]; // [RULE6]
      end
      `FMT_32BIT: begin
        enc_w2 = value_q[31:16]; // [RULE6]
        enc_w3 = value_q[15:0]; // [RULE6]
      end
      default: begin
        enc_w2 = value_q[15:0]; // [RULE7]
        enc_w3 = {`DRIVE_OBJECT, value_q[25:16]}; // [RULE7] [RULE10]
      end
    endcase
    // A read carries no value, so both value words go out as zero.
    if (enc_code[3:0] == `RQ_READ_FIELD) begin
      enc_w2 = 16'h0000; // [RULE9]
      enc_w3 = 16'h0000; // [RULE9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoder and acyclic and exchange checks.
  reg [4:0] dec_code;
  reg [15:0] dec_number;
  reg [31:0] dec_value;
  reg hdr_ok;
  reg len_ok;
  reg dx_ok;
  always @* begin
    dec_code = canon_code(chin01_q[31:28]); // [RULE8]
    dec_number = {5'h00, chin01_q[26:16]} + dec_offset; // [RULE2]
    case (dec_code[3:0])
      `RQ_WRITE_WORD: dec_value = {16'h0000, chin23_q[15:0]};
      `RQ_WRITE_DWORD: dec_value = chin23_q; // [RULE20]
      default: dec_value = 32'h0000_0000; // [RULE9]
    endcase
    hdr_ok = (hdr_q[7:0] != 8'h00) && // [RULE14]
      (hdr_q[15:8] == `ACYC_READ_REQ) && // [RULE14]
      (hdr_q[23:16] == `ACYC_HDR_BYTE2) && // [RULE15]
      (hdr_q[31:24] != 8'h00) && // [RULE15] [RULE22]
      (hdr_q[31:24] <= `ACYC_MAX_PARAMS) && // [RULE15] [RULE22]
      ((addr_q[7:0] == `ACYC_ATTR_VALUE) ||
       (addr_q[7:0] == `ACYC_ATTR_DESC)) && // [RULE16]
      (addr_q[15:8] <= `ACYC_MAX_INDEXES) && // [RULE17]
      (addr_q[31:16] != 16'h0000) && // [RULE18]
      ((addr_q[15:8] != 8'h00) ||
       (idx_len_q[15:0] == 16'h0000)); // [RULE19]
    len_ok = (idx_len_q[31:16] <= `ACYC_MAX_BYTES); // [RULE13]
    dx_ok = (dx_cfg_q[4:0] <= `DX_MAX_WORDS) && // [RULE11]
      (dx_cfg_q[10:8] <= `DX_MAX_LINKS) && // [RULE11]
      dx_cfg_q[16]; // [RULE12]
  end

  // Status events raised by the finishing operation.
  reg [6:0] st_set;
  always @* begin
    st_set = 7'h00;
    if (state_q == S_WORK) begin
      st_set[`ST_DONE] = 1'b1;
      if (op_q[`CMD_ENCODE]) begin
        st_set[`ST_ILLEGAL_NUM] = ~enc_ok;
        st_set[`ST_BAD_CODE] = ~enc_code[4];
      end
      if (op_q[`CMD_DECODE]) begin
        st_set[`ST_BAD_CODE] = ~dec_code[4];
        st_set[`ST_ILLEGAL_NUM] = dec_code[4] & ~dec_ok; // [RULE23]
      end
      if (op_q[`CMD_HDR_CHECK]) begin
        st_set[`ST_HDR_BAD] = ~hdr_ok; // [RULE22]
        st_set[`ST_TOO_BIG] = ~len_ok; // [RULE13]
      end
      if (op_q[`CMD_DX_CHECK]) begin
        st_set[`ST_DX_REJECT] = ~dx_ok;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: every access waits one cycle with clock_en high, then completes.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      readdata_q <= 32'h0000_0000;
    end else if (clock_en) begin
      ack_q <= bus_go;
      if (read & ~ack_q) begin
        case (wa)
          `REG_NUMBER: readdata_q <= {16'h0000, num_q};
          `REG_CTRL: readdata_q <= ctrl_q;
          `REG_VALUE: readdata_q <= value_q;
          `REG_STATUS: readdata_q <= {25'h0, status_q[6:1],
                                      state_q == S_WORK};
          `REG_CHIN01: readdata_q <= chin01_q;
          `REG_CHIN23: readdata_q <= chin23_q;
          `REG_CHOUT01: readdata_q <= chout01_q;
          `REG_CHOUT23: readdata_q <= chout23_q;
          `REG_DEC_RESULT: readdata_q <= dec_result_q;
          `REG_DEC_VALUE: readdata_q <= dec_value_q;
          `REG_ACYC_HDR: readdata_q <= hdr_q;
          `REG_ACYC_ADDR: readdata_q <= addr_q;
          `REG_ACYC_IDX_LEN: readdata_q <= idx_len_q;
          `REG_DX_CFG: readdata_q <= dx_cfg_q;
          `REG_ACYC_RESP: readdata_q <= acyc_resp_q;
          default: readdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Software registers; the control fields keep only their defined bits.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      num_q <= 16'h0000;
      ctrl_q <= 32'h0000_0000;
      value_q <= 32'h0000_0000;
      chin01_q <= 32'h0000_0000;
      chin23_q <= 32'h0000_0000;
      hdr_q <= 32'h0000_0000;
      addr_q <= 32'h0000_0000;
      idx_len_q <= 32'h0000_0000;
      dx_cfg_q <= 32'h0000_0000;
    end else if (clock_en && wr_go) begin
      case (wa)
        `REG_NUMBER: num_q <= num_wr[15:0];
        `REG_CTRL: ctrl_q <= merge(ctrl_q, writedata, byteenable) &
                             32'h0003_FF0F;
        `REG_VALUE: value_q <= merge(value_q, writedata, byteenable);
        `REG_CHIN01: chin01_q <= merge(chin01_q, writedata, byteenable);
        `REG_CHIN23: chin23_q <= merge(chin23_q, writedata, byteenable);
        `REG_ACYC_HDR: hdr_q <= merge(hdr_q, writedata, byteenable);
        `REG_ACYC_ADDR: addr_q <= merge(addr_q, writedata, byteenable);
        `REG_ACYC_IDX_LEN: idx_len_q <= merge(idx_len_q, writedata,
                                              byteenable);
        `REG_DX_CFG: dx_cfg_q <= merge(dx_cfg_q, writedata, byteenable) &
                                 32'h0001_071F;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operation sequencer. A command written while busy is dropped; the busy
  // window is a single cycle, so software sees it only if it polls hard.
  wire cmd_wr = wr_go && (wa == `REG_CMD) && byteenable[0];
  wire [3:0] op_d = writedata[3:0] & (~writedata[3:0] + 4'h1);

  // A status bit written with one is cleared unless it is set in that cycle.
  wire [6:0] st_clr = (wr_go && (wa == `REG_STATUS) && byteenable[0]) ?
                      writedata[6:0] : 7'h00;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= S_IDLE;
      op_q <= 4'h0;
      status_q <= 7'h00;
      chout01_q <= 32'h0000_0000;
      chout23_q <= 32'h0000_0000;
      dec_result_q <= 32'h0000_0000;
      dec_value_q <= 32'h0000_0000;
      acyc_resp_q <= 32'h0000_0000;
      dx_enable_q <= 1'b0;
    end else if (clock_en) begin
      status_q <= (status_q & ~st_clr) | st_set;
      case (state_q)
        S_IDLE: begin
          if (cmd_wr && (op_d != 4'h0)) begin
            op_q <= op_d;
            state_q <= S_WORK;
          end
        end
        S_WORK: begin
          state_q <= S_IDLE;
          if (op_q[`CMD_ENCODE] && enc_ok && enc_code[4]) begin
            chout01_q <= {enc_w0, enc_w1};
            chout23_q <= {enc_w2, enc_w3};
          end
          if (op_q[`CMD_DECODE]) begin
            if (!dec_code[4] || !dec_ok) begin
              chout01_q <= {`RESP_ERROR, chin01_q[27:0]}; // [RULE21]
              chout23_q <= {16'h0000, dec_code[4] ? `ERR_ILLEGAL_NUMBER :
                            `ERR_NOT_SUPPORTED}; // [RULE21] [RULE23]
            end else begin
              dec_result_q <= {chin01_q[15:8], 4'h0, dec_code[3:0],
                               dec_number}; // [RULE4] [RULE2]
              dec_value_q <= dec_value;
            end
          end
          if (op_q[`CMD_HDR_CHECK]) begin
            acyc_resp_q <= {hdr_q[31:24], `ACYC_HDR_BYTE2,
                            (hdr_ok && len_ok) ? `ACYC_RESP_OK :
                            `ACYC_RESP_FAIL, hdr_q[7:0]}; // [RULE22]
          end
          if (op_q[`CMD_DX_CHECK]) begin
            dx_enable_q <= dx_ok; // [RULE11] [RULE12]
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule // param_channel_codec

// ===== verilog/param_channel_defs.vh
// Constants shared by the parameter channel codec and its page index map.
// Assumes inclusion by bare name from files under verilog/.
`ifndef PARAM_CHANNEL_DEFS_VH
`define PARAM_CHANNEL_DEFS_VH

// Register byte addresses on the Avalon-MM slave.
`define REG_NUMBER 8'h00
`define REG_CTRL 8'h04
`define REG_VALUE 8'h08
`define REG_CMD 8'h0C
`define REG_STATUS 8'h10
`define REG_CHIN01 8'h14
`define REG_CHIN23 8'h18
`define REG_CHOUT01 8'h1C
`define REG_CHOUT23 8'h20
`define REG_DEC_RESULT 8'h24
`define REG_DEC_VALUE 8'h28
`define REG_ACYC_HDR 8'h2C
`define REG_ACYC_ADDR 8'h30
`define REG_ACYC_IDX_LEN 8'h34
`define REG_DX_CFG 8'h38
`define REG_ACYC_RESP 8'h3C

// Command bits.
`define CMD_ENCODE 0
`define CMD_DECODE 1
`define CMD_HDR_CHECK 2
`define CMD_DX_CHECK 3

// Status bits.
`define ST_BUSY 0
`define ST_DONE 1
`define ST_ILLEGAL_NUM 2
`define ST_BAD_CODE 3
`define ST_HDR_BAD 4
`define ST_TOO_BIG 5
`define ST_DX_REJECT 6

// Value formats in the control register.
`define FMT_8BIT 2'h0
`define FMT_16BIT 2'h1
`define FMT_32BIT 2'h2
`define FMT_CONNECTOR 2'h3

// Request and response codes of the cyclic channel.
`define RQ_READ_FIELD 4'h6
`define RQ_WRITE_WORD 4'h7
`define RQ_WRITE_DWORD 4'h8
`define RESP_ERROR 4'h7
`define ERR_ILLEGAL_NUMBER 16'h0000
`define ERR_NOT_SUPPORTED 16'h006A

// Page index table, entry 0 in the low bits.
`define PAGE_ENTRIES 8
`define PAGE_OFFSETS {16'hEA60, 16'h7530, 16'h4E20, 16'h2710, \
  16'h1F40, 16'h1770, 16'h07D0, 16'h0000}
`define PAGE_CODES {8'h74, 8'hF0, 8'h50, 8'hA0, 8'h20, 8'h90, 8'h80, 8'h00}
`define PAGE_RANGE 17'h007D0
`define DRIVE_OBJECT 6'h3F

// Acyclic read request header and limits.
`define ACYC_READ_REQ 8'h01
`define ACYC_HDR_BYTE2 8'h01
`define ACYC_MAX_PARAMS 8'h27
`define ACYC_ATTR_VALUE 8'h10
`define ACYC_ATTR_DESC 8'h20
`define ACYC_MAX_INDEXES 8'hEA
`define ACYC_MAX_BYTES 16'h00F0
`define ACYC_RESP_OK 8'h01
`define ACYC_RESP_FAIL 8'h81

// Slave-to-slave exchange limits.
`define DX_MAX_WORDS 5'h0C
`define DX_MAX_LINKS 3'h4

`endif
